// ---- core/tcs_map.svh ----
/*
  constants of the transmit clock synthesizer and its fabric controller:
  timing counts, post divider codes, register offsets and field positions.
  assumes a single 25 MHz mclk shared by both ends.
*/
// What this block does
// - flag loss of lock on stopped or wrong reference
// - per lane post divide by 1,2,4,8,11
// - lane clock is half rate, both edges
// - one spread synthesizer, own quad lanes only
// - non spread synthesizer: four lanes, attenuation only
// - spread enable: fractional mode, wave table divider
// - center or down spread, frequency, amplitude
// - jitter attenuator filters reference, drives oscillator
// - spread modulated reference is accepted
// - quad reset aligns up to four lanes
// - shared clock reset resets lanes together
// - lane clocks stopped four cycles during reset
// - alignment completes before lock is shown
// - lane reset hits only its dividers
// - software toggles realign enable high low high
// - lanes across quads use per lane resets
// - over four lanes: fabric resets lanes
// - synthesizer supplies fabric system clock
// - lock output high while locked
// - align pulse 16 cycles, equal dividers
// - reset enable bit set per reset lane
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
// frequency check window and lock qualification
`define TCS_WIN_LAST    6'h3f
`define TCS_LOCK_WINS   2'h2
// shared clock reset stop time and fabric align pulse length
`define TCS_STOP_CYC    3'h4
`define TCS_ALIGN_CYC   5'h10
// post divider codes
`define TCS_PDIV_1      3'h0
`define TCS_PDIV_2      3'h1
`define TCS_PDIV_4      3'h2
`define TCS_PDIV_8      3'h3
`define TCS_PDIV_11     3'h4
// register byte offsets
`define TCS_REG_CTRL    8'h00
`define TCS_REG_DIV     8'h04
`define TCS_REG_SSC     8'h08
`define TCS_REG_LANE    8'h0c
`define TCS_REG_STAT    8'h10
// ctrl fields and reset value
`define TCS_CTRL_REALIGN 0
`define TCS_CTRL_SSC_EN  1
`define TCS_CTRL_DOWN    2
`define TCS_CTRL_JA_EN   3
`define TCS_CTRL_ALIGN   4
`define TCS_CTRL_RST     5'h01
// ssc fields
`define TCS_SSC_PER_LSB  16
`define TCS_SSC_AMP_LSB  24
`endif

// ---- core/tcs_pkg.sv ----
/*
  types and shared functions of the synthesizer and fabric controller.
  assumes tcs_map.svh is compiled alongside.
*/
`include "tcs_map.svh"
package tcs_pkg;
  typedef enum logic [1:0] {TCS_ACQ, TCS_STOP, TCS_LOCK} tcs_dev_state_type;

  typedef struct packed {
    logic              ref_s1;
    logic              ref_s2;
    logic              ref_s3;
    logic [5:0]        win_cnt;
    logic [7:0]        ref_edges;
    logic [7:0]        nco_edges;
    logic [1:0]        good_cnt;
    tcs_dev_state_type state;
    logic [2:0]        stop_cnt;
    logic              lock;
    logic              lol;
    logic              clk_reset;
    logic [3:0][3:0]   pdiv_cnt;
    logic [3:0]        lane_clk;
    logic              re_prev;
    logic              re_low_seen;
    logic [2:0]        wave_idx;
    logic [7:0]        mod_cnt;
    logic [15:0]       divval;
    logic              frac_mode;
    logic [15:0]       nco_acc;
    logic [15:0]       nco_inc;
    logic              nco_prev;
    logic [3:0]        sys_cnt;
    logic              sys_clk;
  } tcs_dev_type;

  typedef struct packed {
    logic        lock_s1;
    logic        lock_s2;
    logic        lock_prev;
    logic [4:0]  ctrl;
    logic [11:0] div;
    logic [15:0] base;
    logic [7:0]  period;
    logic [3:0]  amp;
    logic [3:0]  rst_en;
    logic [3:0]  sw_rst;
    logic [4:0]  align_cnt;
    logic        align_busy;
    logic        mismatch;
    logic [3:0]  lane_rst_n;
    logic [31:0] prdata;
    logic        pslverr;
  } tcs_fab_type;

  // post divider code to divide ratio; unknown codes fall back to 1
  function automatic logic [3:0] pdiv_val(input logic [2:0] code);
    case (code)
      `TCS_PDIV_2:  pdiv_val = 4'h2;
      `TCS_PDIV_4:  pdiv_val = 4'h4;
      `TCS_PDIV_8:  pdiv_val = 4'h8;
      `TCS_PDIV_11: pdiv_val = 4'hb;
      default:      pdiv_val = 4'h1;
    endcase
  endfunction
endpackage

// ---- core/tcs_link_if.sv ----
/*
  link between the synthesizer end and the fabric control end.
  assumes both ends run on the same mclk; the bench connects them.
*/
`timescale 1ns/10ps
interface tcs_link_if;
  // synthesizer to fabric
  logic             lock;
  logic             lol;
  logic [3:0]       lane_clk;
  logic             lane_clk_reset;
  logic             sys_clk;
  logic             frac_mode;
  logic [15:0]      divval;
  logic             ja_clk;
  // fabric to synthesizer
  logic             realign_en;
  logic             ssc_en;
  logic             ssc_down;
  logic [7:0]       ssc_period;
  logic [3:0]       ssc_amp;
  logic [15:0]      base_divval;
  logic             ja_en;
  logic [3:0][2:0]  pdiv_code;
  logic [3:0]       lane_async_reset_n;
  logic [3:0]       lane_reset_enable;

  modport dev (
    output lock, lol, lane_clk, lane_clk_reset, sys_clk, frac_mode, divval, ja_clk,
    input  realign_en, ssc_en, ssc_down, ssc_period, ssc_amp, base_divval, ja_en,
    input  pdiv_code, lane_async_reset_n, lane_reset_enable
  );
  modport fab (
    input  lock, lol, lane_clk, lane_clk_reset, sys_clk, frac_mode, divval, ja_clk,
    output realign_en, ssc_en, ssc_down, ssc_period, ssc_amp, base_divval, ja_en,
    output pdiv_code, lane_async_reset_n, lane_reset_enable
  );
endinterface

// ---- core/tcs_synth_dev.sv ----
/*
  transmit clock synthesizer end: reference check and lock, shared lane
  clock reset, per lane post dividers, spread modulation of the feedback
  divide value, jitter attenuating oscillator and fabric system clock.
  assumes ref_clk_in is a pin slower than mclk/2; the synthesizer base
  rate is modelled as one tick per mclk.
*/
`timescale 1ns/10ps
`include "tcs_map.svh"
module tcs_synth_dev #(
  parameter logic [7:0]      REF_MIN   = 8'h06,
  parameter logic [7:0]      REF_MAX   = 8'h0a,
  parameter bit              SPREAD    = 1'b1,
  parameter logic [3:0]      SERVED    = 4'hf,
  parameter logic [3:0]      SYS_DIV   = 4'h2,
  parameter logic [3:0]      WAVE_MID  = 4'h4,
  parameter logic [7:0][3:0] WAVE      = {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8},
  parameter logic [15:0]     NCO_INIT  = 16'h1000
) (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  // reference clock pin
  input  wire logic  ref_clk_in,
  // link to lanes and fabric
  tcs_link_if.dev    lnk
);
  tcs_pkg::tcs_dev_type s_r;
  tcs_pkg::tcs_dev_type s_nxt;

  logic        ref_edge;
  logic        win_end;
  logic        win_good;
  logic        realign_trig;
  logic        ssc_on;
  logic [7:0]  wave_amp;
  logic [7:0]  mid_amp;
  logic [7:0]  nco_err;
  logic        nco_edge;
  logic [3:0]  lane_rst;

  // next state of the whole synthesizer
  always_comb begin
    s_nxt = s_r;
    // reference pin synchronizer, edge taken from the second stage on
    s_nxt.ref_s1 = ref_clk_in;
    s_nxt.ref_s2 = s_r.ref_s1;
    s_nxt.ref_s3 = s_r.ref_s2;
    ref_edge = s_r.ref_s2 & ~s_r.ref_s3;
    // oscillator edges for the attenuator comparison; the new msb is
    // compared with the registered one so that a rising edge is seen
    s_nxt.nco_acc = s_r.nco_acc + s_r.nco_inc;
    nco_edge = s_nxt.nco_acc[15] & ~s_r.nco_prev;
    win_end = (s_r.win_cnt == `TCS_WIN_LAST);
    // edge count in range means toggling at the right frequency; the
    // range is wide enough to pass a spread modulated reference
    win_good = (s_r.ref_edges >= REF_MIN) && (s_r.ref_edges <= REF_MAX);
    // realign after a high, low, high sequence of the enable
    realign_trig = lnk.realign_en & ~s_r.re_prev & s_r.re_low_seen;
    s_nxt.re_prev = lnk.realign_en;
    if (!lnk.realign_en && s_r.re_prev) begin
      s_nxt.re_low_seen = 1'b1;
    end
    // frequency window
    s_nxt.win_cnt = s_r.win_cnt + 6'h01;
    s_nxt.ref_edges = s_r.ref_edges + {7'h00, ref_edge};
    s_nxt.nco_edges = s_r.nco_edges + {7'h00, nco_edge};
    if (win_end) begin
      s_nxt.ref_edges = 8'h00;
      s_nxt.nco_edges = 8'h00;
    end
    // lock sequencing
    unique case (s_r.state)
      tcs_pkg::TCS_ACQ: begin
        if (win_end) begin
          if (!win_good) begin
            s_nxt.good_cnt = 2'h0;
          end else if (s_r.good_cnt == `TCS_LOCK_WINS - 2'h1) begin
            s_nxt.good_cnt = 2'h0;
            if (lnk.realign_en) begin
              s_nxt.state = tcs_pkg::TCS_STOP;
              s_nxt.clk_reset = 1'b1;
              s_nxt.stop_cnt = 3'h0;
            end else begin
              s_nxt.state = tcs_pkg::TCS_LOCK;
              s_nxt.lock = 1'b1;
              s_nxt.lol = 1'b0;
            end
          end else begin
            s_nxt.good_cnt = s_r.good_cnt + 2'h1;
          end
        end
      end
      tcs_pkg::TCS_STOP: begin
        s_nxt.stop_cnt = s_r.stop_cnt + 3'h1;
        if (s_r.stop_cnt == `TCS_STOP_CYC - 3'h1) begin
          s_nxt.state = tcs_pkg::TCS_LOCK;
          s_nxt.clk_reset = 1'b0;
          s_nxt.lock = 1'b1;
          s_nxt.lol = 1'b0;
        end
      end
      tcs_pkg::TCS_LOCK: begin
        if (win_end && !win_good) begin
          s_nxt.state = tcs_pkg::TCS_ACQ;
          s_nxt.lock = 1'b0;
          s_nxt.lol = 1'b1;
        end
      end
    endcase
    // forced relock disrupts the loop and realigns the lanes
    if (realign_trig) begin
      s_nxt.state = tcs_pkg::TCS_ACQ;
      s_nxt.lock = 1'b0;
      s_nxt.clk_reset = 1'b0;
      s_nxt.good_cnt = 2'h0;
      s_nxt.re_low_seen = 1'b0;
    end
    // lane post dividers; a lane reset only touches its own divider
    lane_rst = ~lnk.lane_async_reset_n & lnk.lane_reset_enable;
    for (int i = 0; i < 4; i++) begin
      if (s_r.clk_reset || !s_r.lock || !SERVED[i]) begin
        s_nxt.pdiv_cnt[i] = 4'h0;
        s_nxt.lane_clk[i] = 1'b0;
      end else if (lane_rst[i]) begin
        s_nxt.pdiv_cnt[i] = 4'h0;
        s_nxt.lane_clk[i] = 1'b0;
      end else if (s_r.pdiv_cnt[i] >= tcs_pkg::pdiv_val(lnk.pdiv_code[i]) - 4'h1) begin
        s_nxt.pdiv_cnt[i] = 4'h0;
        s_nxt.lane_clk[i] = ~s_r.lane_clk[i];
      end else begin
        s_nxt.pdiv_cnt[i] = s_r.pdiv_cnt[i] + 4'h1;
      end
    end
    // spread modulation of the feedback divide value
    ssc_on = SPREAD && lnk.ssc_en;
    s_nxt.frac_mode = ssc_on;
    wave_amp = {4'h0, WAVE[s_r.wave_idx]} * {4'h0, lnk.ssc_amp};
    mid_amp = {4'h0, WAVE_MID} * {4'h0, lnk.ssc_amp};
    if (!ssc_on) begin
      s_nxt.mod_cnt = 8'h00;
      s_nxt.wave_idx = 3'h0;
      s_nxt.divval = lnk.base_divval;
    end else begin
      if (s_r.mod_cnt >= lnk.ssc_period) begin
        s_nxt.mod_cnt = 8'h00;
        s_nxt.wave_idx = s_r.wave_idx + 3'h1;
      end else begin
        s_nxt.mod_cnt = s_r.mod_cnt + 8'h01;
      end
      if (lnk.ssc_down) begin
        s_nxt.divval = lnk.base_divval - {8'h00, wave_amp};
      end else begin
        s_nxt.divval = lnk.base_divval + {8'h00, wave_amp} - {8'h00, mid_amp};
      end
    end
    // jitter attenuator: integrating filter on the edge count error
    nco_err = s_r.ref_edges - s_r.nco_edges;
    s_nxt.nco_prev = s_nxt.nco_acc[15];
    if (!lnk.ja_en) begin
      s_nxt.nco_inc = NCO_INIT;
    end else if (win_end) begin
      s_nxt.nco_inc = s_r.nco_inc + {{4{nco_err[7]}}, nco_err, 4'h0};
    end
    // fabric system clock from the locked synthesizer
    if (!s_r.lock) begin
      s_nxt.sys_cnt = 4'h0;
      s_nxt.sys_clk = 1'b0;
    end else if (s_r.sys_cnt == SYS_DIV - 4'h1) begin
      s_nxt.sys_cnt = 4'h0;
      s_nxt.sys_clk = ~s_r.sys_clk;
    end else begin
      s_nxt.sys_cnt = s_r.sys_cnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{state: tcs_pkg::TCS_ACQ, re_prev: 1'b1, nco_inc: NCO_INIT, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // link outputs, all from flip-flops
  assign lnk.lock = s_r.lock;
  assign lnk.lol = s_r.lol;
  assign lnk.lane_clk = s_r.lane_clk;
  assign lnk.lane_clk_reset = s_r.clk_reset;
  assign lnk.sys_clk = s_r.sys_clk;
  assign lnk.frac_mode = s_r.frac_mode;
  assign lnk.divval = s_r.divval;
  assign lnk.ja_clk = s_r.nco_prev;
endmodule

// ---- core/tcs_fabric_ctl.sv ----
/*
  fabric control end: apb register file that steers the synthesizer,
  lock synchronizer and the lane alignment reset sequencer.
  assumes the apb master and the synthesizer share mclk.
*/
`timescale 1ns/10ps
`include "tcs_map.svh"
module tcs_fabric_ctl (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output wire logic [31:0]  prdata,
  output wire logic         pready,
  output wire logic         pslverr,
  // link to the synthesizer
  tcs_link_if.fab           lnk
);
  tcs_pkg::tcs_fab_type f_r;
  tcs_pkg::tcs_fab_type f_nxt;

  logic wr;
  logic rd_setup;
  logic lock_rise;
  logic div_equal;

  // next state of the controller
  always_comb begin
    f_nxt = f_r;
    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable;
    // lock passes two flip-flops before the sequencer looks at it
    f_nxt.lock_s1 = lnk.lock;
    f_nxt.lock_s2 = f_r.lock_s1;
    f_nxt.lock_prev = f_r.lock_s2;
    lock_rise = f_r.lock_s2 & ~f_r.lock_prev;
    div_equal = (f_r.div[2:0] == f_r.div[5:3]) && (f_r.div[2:0] == f_r.div[8:6])
             && (f_r.div[2:0] == f_r.div[11:9]);
    // register writes
    if (wr) begin
      case (paddr)
        `TCS_REG_CTRL: f_nxt.ctrl = pwdata[4:0];
        `TCS_REG_DIV: begin
          f_nxt.div = pwdata[11:0];
          f_nxt.mismatch = 1'b0;
        end
        `TCS_REG_SSC: begin
          f_nxt.base = pwdata[15:0];
          f_nxt.period = pwdata[`TCS_SSC_PER_LSB +: 8];
          f_nxt.amp = pwdata[`TCS_SSC_AMP_LSB +: 4];
        end
        `TCS_REG_LANE: begin
          f_nxt.rst_en = pwdata[3:0];
          f_nxt.sw_rst = pwdata[7:4];
        end
        default: ;
      endcase
    end
    // fabric alignment pulse after the synchronized lock rises
    if (f_r.align_busy) begin
      f_nxt.align_cnt = f_r.align_cnt + 5'h01;
      if (f_r.align_cnt == `TCS_ALIGN_CYC - 5'h01) begin
        f_nxt.align_busy = 1'b0;
      end
    end else if (lock_rise && f_r.ctrl[`TCS_CTRL_ALIGN]) begin
      if (div_equal) begin
        f_nxt.align_busy = 1'b1;
        f_nxt.align_cnt = 5'h00;
      end else begin
        f_nxt.mismatch = 1'b1;
      end
    end
    // per lane resets: alignment pulse only on lanes whose enable bit is set, software resets on any lane
    f_nxt.lane_rst_n = ~((f_nxt.align_busy ? f_r.rst_en : 4'h0) | f_r.sw_rst);
    // read data captured in the setup cycle
    if (rd_setup) begin
      f_nxt.prdata = 32'h0000_0000;
      f_nxt.pslverr = 1'b0;
      case (paddr)
        `TCS_REG_CTRL: f_nxt.prdata = {27'h0, f_r.ctrl};
        `TCS_REG_DIV:  f_nxt.prdata = {20'h0, f_r.div};
        `TCS_REG_SSC:  f_nxt.prdata = {4'h0, f_r.amp, f_r.period, f_r.base};
        `TCS_REG_LANE: f_nxt.prdata = {24'h0, f_r.sw_rst, f_r.rst_en};
        `TCS_REG_STAT: f_nxt.prdata = {27'h0, lnk.frac_mode, f_r.mismatch,
                                       f_r.align_busy, lnk.lol, f_r.lock_s2};
        default:       f_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      f_r <= '{ctrl: `TCS_CTRL_RST, lane_rst_n: 4'hf, default: '0};
    end else begin
      f_r <= f_nxt;
    end
  end

  // bus and link outputs
  assign pready = 1'b1;
  assign prdata = f_r.prdata;
  assign pslverr = f_r.pslverr;
  assign lnk.realign_en = f_r.ctrl[`TCS_CTRL_REALIGN];
  assign lnk.ssc_en = f_r.ctrl[`TCS_CTRL_SSC_EN];
  assign lnk.ssc_down = f_r.ctrl[`TCS_CTRL_DOWN];
  assign lnk.ja_en = f_r.ctrl[`TCS_CTRL_JA_EN];
  assign lnk.ssc_period = f_r.period;
  assign lnk.ssc_amp = f_r.amp;
  assign lnk.base_divval = f_r.base;
  assign lnk.pdiv_code = f_r.div;
  assign lnk.lane_async_reset_n = f_r.lane_rst_n;
  assign lnk.lane_reset_enable = f_r.rst_en;
endmodule

// ---- test/tcs_link_checker.sv ----
/*
  link checker: shared stop window, lock order, lane clocks, spread divider.
  assumes one mclk domain; the bench taps the link signals by name.
*/
`timescale 1ns/10ps
module tcs_link_checker (
  // clock and reset
  input wire logic            mclk,
  input wire logic            rst_n,
  // synthesizer outputs
  input wire logic            lock,
  input wire logic            lol,
  input wire logic [3:0]      lane_clk,
  input wire logic            lane_clk_reset,
  input wire logic            frac_mode,
  input wire logic [15:0]     divval,
  // fabric outputs
  input wire logic            realign_en,
  input wire logic            ssc_en,
  input wire logic            ssc_down,
  input wire logic [3:0]      ssc_amp,
  input wire logic [15:0]     base_divval,
  input wire logic [3:0][2:0] pdiv_code,
  input wire logic [3:0]      lane_async_reset_n,
  input wire logic [3:0]      lane_reset_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // amplitude widened to the divider width
  logic [15:0] amp_ext;
  assign amp_ext = {12'h000, ssc_amp};
  // shared reset holds four cycles, then lock follows
  sequence stop_win;
    lane_clk_reset [*4] ##1 !lane_clk_reset;
  endsequence
  sequence lock_soon;
    ##[0:1] lock;
  endsequence
  a_stop_len: assert property ($rose(lane_clk_reset) |-> stop_win)
    else $error("lane clock reset width wrong");
  a_stop_lanes: assert property (lane_clk_reset && $past(lane_clk_reset) |-> lane_clk == 4'h0)
    else $error("lane clocks run during stop");
  a_lock_after: assert property ($fell(lane_clk_reset) |-> lock_soon)
    else $error("lock missing after stop");
  a_lock_order: assert property ($rose(lock) && realign_en |->
    $past(lane_clk_reset) || $past(lane_clk_reset, 2))
    else $error("lock without shared reset");
  a_lol_loss: assert property ($rose(lol) |-> $fell(lock))
    else $error("loss flag without lock drop");
  a_lanes_idle: assert property (!lock && !$past(lock) |-> lane_clk == 4'h0)
    else $error("lane clock while unlocked");
  a_fast_lane: assert property (lock && $past(lock) && $past(lock, 2) && pdiv_code == 12'h000
    && $past(pdiv_code) == 12'h000 && $past(pdiv_code, 2) == 12'h000 && lane_async_reset_n[0]
    && $past(lane_async_reset_n[0]) |-> lane_clk[0] != $past(lane_clk[0]))
    else $error("divide by one lane not toggling");
  a_frac_off: assert property (!ssc_en && !$past(ssc_en) |-> !frac_mode)
    else $error("fractional mode without spread");
  a_div_plain: assert property (!ssc_en && !frac_mode && !$past(frac_mode)
    |-> divval == $past(base_divval))
    else $error("divider not following base");
  a_down_band: assert property (frac_mode && $past(frac_mode) && ssc_down && $stable(ssc_down)
    && $stable(ssc_amp) && $stable(base_divval) |->
    divval <= base_divval - amp_ext && divval >= base_divval - (amp_ext << 3))
    else $error("down spread out of band");
  a_lane_reset: assert property (!lane_async_reset_n[0] && lane_reset_enable[0]
    && !$past(lane_async_reset_n[0]) && $past(lane_reset_enable[0]) |-> !lane_clk[0])
    else $error("reset lane still clocking");
endmodule

// ---- test/test_tx_clock_synth_lane_align.sv ----
/*
  testbench: both ends joined by the link, an apb master and the reference pin.
  assumes default synthesizer parameters: ref window 6..10, all lanes served.
*/
`timescale 1ns/10ps
`include "tcs_map.svh"
module test_tx_clock_synth_lane_align;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic        ref_clk_in;
  logic        ref_run;
  logic        ref_fast;
  logic [2:0]  ref_cnt;
  logic [31:0] rd;
  logic        err;
  logic [15:0] first_dv;
  logic        moved;
  logic        in_band;
  logic        ja_last;
  int          k;
  int          n_errors;
  int          checked;
  logic [3:0]  ratio [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hb};

  tcs_link_if tcs_link_if_i ();
  tcs_synth_dev tcs_synth_dev_i (.mclk(mclk), .rst_n(rst_n), .ref_clk_in(ref_clk_in),
    .lnk(tcs_link_if_i));
  tcs_fabric_ctl tcs_fabric_ctl_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(tcs_link_if_i));
  tcs_link_checker tcs_link_checker_i (.mclk(mclk), .rst_n(rst_n),
    .lock(tcs_link_if_i.lock), .lol(tcs_link_if_i.lol),
    .lane_clk(tcs_link_if_i.lane_clk), .lane_clk_reset(tcs_link_if_i.lane_clk_reset),
    .frac_mode(tcs_link_if_i.frac_mode), .divval(tcs_link_if_i.divval),
    .realign_en(tcs_link_if_i.realign_en), .ssc_en(tcs_link_if_i.ssc_en),
    .ssc_down(tcs_link_if_i.ssc_down), .ssc_amp(tcs_link_if_i.ssc_amp),
    .base_divval(tcs_link_if_i.base_divval), .pdiv_code(tcs_link_if_i.pdiv_code),
    .lane_async_reset_n(tcs_link_if_i.lane_async_reset_n),
    .lane_reset_enable(tcs_link_if_i.lane_reset_enable));

  // 25 MHz clock
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // reference pin: 8 mclk period, 4 when fast, frozen when stopped
  always @(posedge mclk) begin
    if (ref_run) begin
      ref_cnt <= ref_cnt + 3'h1;
      ref_clk_in <= ref_fast ? ref_cnt[1] : ref_cnt[2];
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_lock(input logic v);
    k = 0;
    while (tcs_link_if_i.lock !== v && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    chk({31'h0, tcs_link_if_i.lock}, {31'h0, v});
  endtask

  // lanes 0..3, or 4 for the fabric system clock
  function automatic logic pick(input int ln);
    return (ln < 4) ? tcs_link_if_i.lane_clk[ln] : tcs_link_if_i.sys_clk;
  endfunction

  // cycles between two toggles; 40 means it never toggled
  task automatic meas(input int ln, input logic [7:0] n);
    logic v;
    @(negedge mclk);
    for (int p = 0; p < 2; p++) begin
      v = pick(ln);
      k = 0;
      while (pick(ln) === v && k < 40) begin
        @(negedge mclk);
        k++;
      end
    end
    chk(32'(k), {24'h0, n});
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ref_clk_in = 1'b0;
    ref_run = 1'b1;
    ref_fast = 1'b0;
    ref_cnt = 3'h0;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values and an unmapped offset
    apb(1'b0, `TCS_REG_CTRL, 32'h0);
    chk(rd, {27'h0, `TCS_CTRL_RST});
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // first lock, status and system clock
    wait_lock(1'b1);
    // the status lock bit trails the link by its two synchronizer stages
    repeat (3) @(negedge mclk);
    apb(1'b0, `TCS_REG_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    meas(4, 8'h2);
    // every post divider code on all lanes, measured on lanes 0 and 3
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `TCS_REG_DIV, {20'h0, c[2:0], c[2:0], c[2:0], c[2:0]});
      meas(0, {4'h0, ratio[c]});
      meas(3, {4'h0, ratio[c]});
    end
    // a half toggle leaves lock alone; the full one realigns
    apb(1'b1, `TCS_REG_LANE, 32'h0f);
    apb(1'b1, `TCS_REG_CTRL, 32'h10);
    repeat (4) @(negedge mclk);
    chk({31'h0, tcs_link_if_i.lock}, 32'h1);
    apb(1'b1, `TCS_REG_CTRL, 32'h11);
    wait_lock(1'b0);
    wait_lock(1'b1);
    k = 0;
    while (tcs_link_if_i.lane_async_reset_n !== 4'h0 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    chk({28'h0, tcs_link_if_i.lane_async_reset_n}, 32'h0);
    k = 0;
    while (tcs_link_if_i.lane_async_reset_n[0] === 1'b0 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    chk(32'(k), 32'h10);
    // software lane reset needs its enable bit
    apb(1'b1, `TCS_REG_CTRL, 32'h01);
    apb(1'b1, `TCS_REG_DIV, 32'h0);
    apb(1'b1, `TCS_REG_LANE, 32'h10);
    meas(0, 8'h1);
    apb(1'b1, `TCS_REG_LANE, 32'h11);
    meas(0, 8'h28);
    meas(1, 8'h1);
    apb(1'b1, `TCS_REG_LANE, 32'h00);
    // stopped and wrong rate references both lose lock
    for (int f = 0; f < 2; f++) begin
      if (f == 0) ref_run <= 1'b0;
      else ref_fast <= 1'b1;
      wait_lock(1'b0);
      repeat (3) @(negedge mclk);
      apb(1'b0, `TCS_REG_STAT, 32'h0);
      chk(rd & 32'h3, 32'h2);
      ref_run <= 1'b1;
      ref_fast <= 1'b0;
      wait_lock(1'b1);
    end
    // down spread, center spread, then the plain divider again
    apb(1'b1, `TCS_REG_SSC, 32'h0102_1000);
    apb(1'b1, `TCS_REG_CTRL, 32'h07);
    repeat (40) @(negedge mclk);
    chk({31'h0, tcs_link_if_i.frac_mode}, 32'h1);
    apb(1'b1, `TCS_REG_CTRL, 32'h03);
    repeat (4) @(negedge mclk);
    first_dv = tcs_link_if_i.divval;
    moved = 1'b0;
    in_band = 1'b1;
    repeat (40) begin
      @(negedge mclk);
      if (tcs_link_if_i.divval < 16'h0ffd || tcs_link_if_i.divval > 16'h1004) in_band = 1'b0;
      if (tcs_link_if_i.divval !== first_dv) moved = 1'b1;
    end
    chk({31'h0, in_band}, 32'h1);
    chk({31'h0, moved}, 32'h1);
    apb(1'b1, `TCS_REG_CTRL, 32'h01);
    repeat (3) @(negedge mclk);
    chk({31'h0, tcs_link_if_i.frac_mode}, 32'h0);
    chk({16'h0, tcs_link_if_i.divval}, 32'h1000);
    // attenuator: oscillator settles to the 8 cycle reference rate
    apb(1'b1, `TCS_REG_CTRL, 32'h09);
    repeat (12000) @(negedge mclk);
    ja_last = tcs_link_if_i.ja_clk;
    k = 0;
    repeat (640) begin
      @(negedge mclk);
      if (tcs_link_if_i.ja_clk === 1'b1 && ja_last === 1'b0) k++;
      ja_last = tcs_link_if_i.ja_clk;
    end
    in_band = (k >= 64) && (k <= 96);
    chk({31'h0, in_band}, 32'h1);
    summarize();
  end
endmodule
